/* pkg/uq_pkg.sv */
package uq_pkg;
  localparam int unsigned UQ_CHANNELS = 4;
  // Register index inside a channel, byte address is index times four
  localparam logic [4:0] UQ_IX_DIV_LO = 5'h00;
  localparam logic [4:0] UQ_IX_DIV_HI = 5'h01;
  localparam logic [4:0] UQ_IX_RX_HOLD = 5'h02;
  localparam logic [4:0] UQ_IX_TX_HOLD = 5'h03;
  localparam logic [4:0] UQ_IX_INT_EN = 5'h04;
  localparam logic [4:0] UQ_IX_FIFO_CTL = 5'h05;
  localparam logic [4:0] UQ_IX_INT_STAT = 5'h06;
  localparam logic [4:0] UQ_IX_LINE_CTL = 5'h07;
  localparam logic [4:0] UQ_IX_MODEM_CTL = 5'h08;
  localparam logic [4:0] UQ_IX_LINE_STAT = 5'h09;
  localparam logic [4:0] UQ_IX_MODEM_STAT = 5'h0A;
  localparam logic [4:0] UQ_IX_SCRATCH = 5'h0B;
  localparam logic [4:0] UQ_IX_FIFO_LVL = 5'h0C;
  localparam logic [4:0] UQ_IX_TRIGGER = 5'h0D;
  localparam logic [4:0] UQ_IX_FEAT_CTL = 5'h0E;
  localparam logic [4:0] UQ_IX_ENH_FEAT = 5'h0F;
  localparam logic [4:0] UQ_IX_RESUME1 = 5'h10;
  localparam logic [4:0] UQ_IX_RESUME2 = 5'h11;
  localparam logic [4:0] UQ_IX_PAUSE1 = 5'h12;
  localparam logic [4:0] UQ_IX_PAUSE2 = 5'h13;
  // Block-wide registers
  localparam logic [11:0] UQ_OFS_SUMMARY = 12'h200;
  localparam logic [11:0] UQ_OFS_IRQ_STAT = 12'h204;
  localparam logic [11:0] UQ_OFS_IRQ_MASK = 12'h208;
  // Values after reset
  localparam logic [7:0] UQ_RST_ZERO = 8'h00;
  localparam logic [7:0] UQ_RST_INT_STAT = 8'h01;
  localparam logic [7:0] UQ_RST_LINE_STAT = 8'h60;
  localparam logic [7:0] UQ_RST_SCRATCH = 8'hFF;
  // Field positions
  localparam int unsigned UQ_EFR_ENH = 4;
  localparam int unsigned UQ_FEATURE_CONTROL_SWAP = 6;
  localparam int unsigned UQ_MCR_DTR = 0;
  localparam int unsigned UQ_MCR_RTS = 1;
  localparam int unsigned UQ_MCR_OUT2 = 3;
  localparam int unsigned UQ_MCR_LOOP = 4;
  localparam int unsigned UQ_IER_MODEM = 3;
  // Cycles until the modem synchronisers carry real pin levels
  localparam logic [1:0] UQ_SETTLE_CYCLES = 2'h3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } uq_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } uq_apb_rsp_t;

  typedef struct packed {
    logic [7:0] int_en;
    logic [7:0] fifo_ctl;
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [7:0] scratch;
    logic [7:0] enh_mode;
    logic [7:0] trigger;
    logic [7:0] feat_ctl;
    logic [7:0] enh_feat;
    logic [7:0] resume1;
    logic [7:0] resume2;
    logic [7:0] pause1;
    logic [7:0] pause2;
    logic [3:0] modem_delta;
  } uq_chan_t;
endpackage

/* logic/uq_quad_uart.sv */
module uq_quad_uart import uq_pkg::*; #(
  parameter int unsigned CH_COUNT = UQ_CHANNELS,
  parameter bit DRIVEN_INT = 1'b0
) (
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // Register bus
  input wire uq_apb_req_t apb_req,
  output uq_apb_rsp_t apb_rsp,
  // Modem inputs, active low
  input wire logic [3:0] cts_n,
  input wire logic [3:0] dsr_n,
  input wire logic [3:0] ri_n,
  input wire logic [3:0] cd_n,
  // Bus style pins
  input wire logic bus_style_motorola,
  input wire logic irq_style_select,
  // Serial and modem outputs
  output logic [3:0] tx_out,
  output logic [3:0] infrared_tx_out,
  output logic [3:0] rts_n,
  output logic [3:0] dtr_n,
  // DMA ready outputs
  output logic [3:0] rx_dma_ready_n,
  output logic [3:0] tx_dma_ready_n,
  // Channel interrupts, three-state, and the always-driven shared request irq_n
  output logic [3:0] int_out,
  output logic [3:0] int_oe_n,
  output logic irq_n,
  // Block interrupt
  output logic irq
);
  uq_chan_t chan [CH_COUNT];
  logic [7:0] div_lo [CH_COUNT];
  logic [7:0] div_hi [CH_COUNT];
  logic [7:0] tx_hold [CH_COUNT];
  logic [7:0] chan_rd [CH_COUNT];
  logic [CH_COUNT-1:0] pending;
  logic [CH_COUNT-1:0] modem_evt;
  logic [15:0] pin_s1;
  logic [15:0] pin_s2;
  logic [15:0] pin_prev;
  logic [1:0] settle;
  logic [1:0] style_s1;
  logic [1:0] style_s2;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic glb_hit;
  logic hit;
  logic ch_hit;
  logic [4:0] idx;
  logic [1:0] sel_ch;
  logic [7:0] rd8;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign wr = access && apb_req.pwrite;
  assign rd = access && !apb_req.pwrite;
  assign idx = apb_req.paddr[6:2];
  assign sel_ch = apb_req.paddr[8:7];
  assign glb_hit = apb_req.paddr == UQ_OFS_SUMMARY
    || apb_req.paddr == UQ_OFS_IRQ_STAT
    || apb_req.paddr == UQ_OFS_IRQ_MASK;
  // Unmapped or misaligned addresses must never reach a channel
  assign ch_hit = apb_req.paddr[11:9] == 3'h0 && apb_req.paddr[1:0] == 2'h0
    && idx <= UQ_IX_PAUSE2 && 32'(sel_ch) < CH_COUNT;

  always_comb begin
    hit = glb_hit;
    rd8 = 8'h00;
    if (ch_hit) begin
      hit = 1'b1;
      rd8 = chan_rd[sel_ch];
    end else if (apb_req.paddr == UQ_OFS_SUMMARY) begin
      rd8 = {rx_dma_ready_n, ~tx_dma_ready_n};
    end else if (apb_req.paddr == UQ_OFS_IRQ_STAT) begin
      rd8 = {4'h0, irq_stat};
    end else if (apb_req.paddr == UQ_OFS_IRQ_MASK) begin
      rd8 = {4'h0, irq_mask};
    end
  end

  // Zero wait: answer is loaded in setup, so access lasts one cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= setup;
      apb_rsp.pslverr <= setup && !hit;
      if (setup) begin
        apb_rsp.prdata <= apb_req.pwrite ? 32'h0 : {24'h0, rd8};
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_s1 <= 16'hFFFF;
      pin_s2 <= 16'hFFFF;
      pin_prev <= 16'hFFFF;
      settle <= 2'h0;
      style_s1 <= 2'h0;
      style_s2 <= 2'h0;
    end else begin
      pin_s1 <= {cd_n, ri_n, dsr_n, cts_n};
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
      style_s1 <= {bus_style_motorola, irq_style_select};
      style_s2 <= style_s1;
      if (settle != UQ_SETTLE_CYCLES) begin
        settle <= settle + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  // one copy per channel
  for (genvar g = 0; g < CH_COUNT; g++) begin : g_ch
    logic cw;
    logic [3:0] now;
    logic [3:0] was;
    logic [3:0] chg;
    logic enh;
    logic [7:0] w;
    logic [7:0] interrupt_status;
    assign cw = wr && ch_hit && sel_ch == 2'(g);
    assign w = apb_req.pwdata[7:0];
    assign enh = chan[g].enh_feat[UQ_EFR_ENH];
    assign now = {pin_s2[12+g], pin_s2[8+g], pin_s2[4+g], pin_s2[g]};
    assign was = {pin_prev[12+g], pin_prev[8+g], pin_prev[4+g], pin_prev[g]};
    // Ring indicator flags only its trailing edge
    assign chg = settle == UQ_SETTLE_CYCLES
      ? {now[3] ^ was[3], now[2] & ~was[2], now[1:0] ^ was[1:0]} : 4'h0;
    assign modem_evt[g] = |(chg & ~chan[g].modem_delta);
    assign pending[g] = chan[g].int_en[UQ_IER_MODEM] && |chan[g].modem_delta;
    assign interrupt_status = pending[g] ? {{2{chan[g].fifo_ctl[0]}}, 6'h00}
      : {{2{chan[g].fifo_ctl[0]}}, 6'h00} | UQ_RST_INT_STAT;

    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        chan[g] <= '0;
        chan[g].scratch <= UQ_RST_SCRATCH;
      end else begin
        if (rd && ch_hit && sel_ch == 2'(g) && idx == UQ_IX_MODEM_STAT) begin
          chan[g].modem_delta <= chg;
        end else begin
          chan[g].modem_delta <= chan[g].modem_delta | chg;
        end
        if (cw) begin
          case (idx)
            UQ_IX_INT_EN: chan[g].int_en <= {enh ? w[7:4] : chan[g].int_en[7:4], w[3:0]};
            UQ_IX_FIFO_CTL: chan[g].fifo_ctl <=
              {w[7:6], enh ? w[5:4] : chan[g].fifo_ctl[5:4], w[3:0]};
            UQ_IX_MODEM_CTL: chan[g].modem_ctl <=
              {enh ? w[7:5] : chan[g].modem_ctl[7:5], w[4:0]};
            UQ_IX_LINE_CTL: chan[g].line_ctl <= w;
            UQ_IX_SCRATCH: begin
              // Swap mode steers the write to the mode register
              if (chan[g].feat_ctl[UQ_FEATURE_CONTROL_SWAP]) begin
                chan[g].enh_mode <= w;
              end else begin
                chan[g].scratch <= w;
              end
            end
            UQ_IX_TRIGGER: chan[g].trigger <= w;
            UQ_IX_FEAT_CTL: chan[g].feat_ctl <= w;
            UQ_IX_ENH_FEAT: chan[g].enh_feat <= w;
            UQ_IX_RESUME1: chan[g].resume1 <= w;
            UQ_IX_RESUME2: chan[g].resume2 <= w;
            UQ_IX_PAUSE1: chan[g].pause1 <= w;
            UQ_IX_PAUSE2: chan[g].pause2 <= w;
            default: ;
          endcase
        end
      end
    end

    // no reset on divisor and holding
    always_ff @(posedge clk_sys) begin
      if (cw && idx == UQ_IX_DIV_LO) begin
        div_lo[g] <= w;
      end
      if (cw && idx == UQ_IX_DIV_HI) begin
        div_hi[g] <= w;
      end
      if (cw && idx == UQ_IX_TX_HOLD) begin
        tx_hold[g] <= w;
      end
    end

    always_comb begin
      case (idx)
        UQ_IX_DIV_LO: chan_rd[g] = div_lo[g];
        UQ_IX_DIV_HI: chan_rd[g] = div_hi[g];
        UQ_IX_INT_EN: chan_rd[g] = chan[g].int_en;
        UQ_IX_INT_STAT: chan_rd[g] = interrupt_status;
        UQ_IX_LINE_CTL: chan_rd[g] = chan[g].line_ctl;
        UQ_IX_MODEM_CTL: chan_rd[g] = chan[g].modem_ctl;
        UQ_IX_LINE_STAT: chan_rd[g] = UQ_RST_LINE_STAT;
        UQ_IX_MODEM_STAT: chan_rd[g] = {~now, chan[g].modem_delta};
        UQ_IX_SCRATCH: chan_rd[g] =
          chan[g].feat_ctl[UQ_FEATURE_CONTROL_SWAP] ? UQ_RST_ZERO : chan[g].scratch;
        UQ_IX_FEAT_CTL: chan_rd[g] = chan[g].feat_ctl;
        UQ_IX_ENH_FEAT: chan_rd[g] = chan[g].enh_feat;
        UQ_IX_RESUME1: chan_rd[g] = chan[g].resume1;
        UQ_IX_RESUME2: chan_rd[g] = chan[g].resume2;
        UQ_IX_PAUSE1: chan_rd[g] = chan[g].pause1;
        UQ_IX_PAUSE2: chan_rd[g] = chan[g].pause2;
        // Level and count stay zero with no FIFO behind them
        default: chan_rd[g] = UQ_RST_ZERO;
      endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        tx_out[g] <= 1'b1;
        infrared_tx_out[g] <= 1'b0;
        rts_n[g] <= 1'b1;
        dtr_n[g] <= 1'b1;
        rx_dma_ready_n[g] <= 1'b1;
        tx_dma_ready_n[g] <= 1'b0;
        // float or drive low per variant
        int_out[g] <= 1'b0;
        int_oe_n[g] <= !DRIVEN_INT;
      end else begin
        tx_out[g] <= 1'b1;
        infrared_tx_out[g] <= 1'b0;
        rx_dma_ready_n[g] <= 1'b1;
        tx_dma_ready_n[g] <= 1'b0;
        // Loopback keeps the modem pins inactive
        rts_n[g] <= !chan[g].modem_ctl[UQ_MCR_RTS] || chan[g].modem_ctl[UQ_MCR_LOOP];
        dtr_n[g] <= !chan[g].modem_ctl[UQ_MCR_DTR] || chan[g].modem_ctl[UQ_MCR_LOOP];
        int_out[g] <= pending[g];
        int_oe_n[g] <= !(DRIVEN_INT || chan[g].modem_ctl[UQ_MCR_OUT2]);
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      irq <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      // Write one clears, a new event in the same cycle survives
      if (wr && apb_req.paddr == UQ_OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~apb_req.pwdata[3:0]) | modem_evt;
      end else begin
        irq_stat <= irq_stat | modem_evt;
      end
      if (wr && apb_req.paddr == UQ_OFS_IRQ_MASK) begin
        irq_mask <= apb_req.pwdata[3:0];
      end
      irq <= |(irq_stat & irq_mask);
      // shared request only in Motorola style, select low
      irq_n <= !(style_s2[1] && !style_s2[0] && |pending);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_tx_idle;
    @(posedge clk_sys) disable iff (reset) tx_out == 4'hF && infrared_tx_out == 4'h0;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("transmit idle level wrong");

  property p_rts;
    @(posedge clk_sys) disable iff (reset)
      rts_n[0] == !($past(chan[0].modem_ctl[1]) && !$past(chan[0].modem_ctl[4]));
  endproperty
  a_rts: assert property (p_rts) else $error("rts_n does not follow control");

  property p_dma;
    @(posedge clk_sys) disable iff (reset) rx_dma_ready_n == 4'hF && tx_dma_ready_n == 4'h0;
  endproperty
  a_dma: assert property (p_dma) else $error("DMA ready levels wrong");

  property p_line_stat;
    @(posedge clk_sys) disable iff (reset)
      rd && apb_req.paddr == 12'h024 |-> apb_rsp.prdata == 32'h60;
  endproperty
  a_line_stat: assert property (p_line_stat) else $error("line status not 0x60");

  property p_isr_idle;
    @(posedge clk_sys) disable iff (reset)
      rd && apb_req.paddr == 12'h018 && !$past(pending[0]) && chan[0].fifo_ctl[0] == 1'b0
      |-> apb_rsp.prdata == 32'h01;
  endproperty
  a_isr_idle: assert property (p_isr_idle) else $error("idle interrupt status wrong");

  property p_scratch_reset;
    @(posedge clk_sys) disable iff (reset) $fell(reset) |-> chan[1].scratch == 8'hFF;
  endproperty
  a_scratch_reset: assert property (p_scratch_reset) else $error("scratch not 0xFF");

  property p_enh_latch;
    @(posedge clk_sys) disable iff (reset)
      !chan[0].enh_feat[4] |=> $stable(chan[0].int_en[7:4]);
  endproperty
  a_enh_latch: assert property (p_enh_latch) else $error("enhanced bits changed");

  property p_delta_quiet;
    @(posedge clk_sys) disable iff (reset)
      settle != 2'h3 |-> chan[0].modem_delta == 4'h0;
  endproperty
  a_delta_quiet: assert property (p_delta_quiet) else $error("early modem change");

  property p_irq_n;
    @(posedge clk_sys) disable iff (reset) !$past(style_s2[1]) |-> irq_n;
  endproperty
  a_irq_n: assert property (p_irq_n) else $error("irq_n active outside Motorola");

  property p_hold;
    @(posedge clk_sys) disable iff (reset) !wr |=> $stable(chan[2].line_ctl);
  endproperty
  a_hold: assert property (p_hold) else $error("line control changed unwritten");

  property p_answer;
    @(posedge clk_sys) disable iff (reset) setup |=> apb_rsp.pready ##1 !apb_rsp.pready;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong");

  property p_int_float;
    @(posedge clk_sys) disable iff (reset)
      !DRIVEN_INT && !chan[0].modem_ctl[UQ_MCR_OUT2] |=> int_oe_n[0];
  endproperty
  a_int_float: assert property (p_int_float) else $error("int output driven");

  property p_irq_n_active;
    @(posedge clk_sys) disable iff (reset)
      style_s2 == 2'h2 && |pending |=> !irq_n;
  endproperty
  a_irq_n_active: assert property (p_irq_n_active) else $error("irq_n not asserted");

  property p_irq_level;
    @(posedge clk_sys) disable iff (reset) |(irq_stat & irq_mask) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq low with unmasked status");

  property p_w1c_set;
    @(posedge clk_sys) disable iff (reset)
      wr && apb_req.paddr == UQ_OFS_IRQ_STAT
      |=> (irq_stat & $past(modem_evt)) == $past(modem_evt);
  endproperty
  a_w1c_set: assert property (p_w1c_set) else $error("event lost on status clear");

  c_irq_n_low: cover property (@(posedge clk_sys) disable iff (reset) $fell(irq_n));
  c_w1c_collide: cover property (@(posedge clk_sys) disable iff (reset)
    wr && apb_req.paddr == UQ_OFS_IRQ_STAT && |modem_evt);
  c_modem_irq: cover property (@(posedge clk_sys) disable iff (reset) $rose(irq));
  c_swap_wr: cover property (@(posedge clk_sys) disable iff (reset)
    wr && idx == UQ_IX_SCRATCH && chan[0].feat_ctl[6]);
  c_unmapped: cover property (@(posedge clk_sys) disable iff (reset) apb_rsp.pslverr);
endmodule

/* testbench/uq_modem_model.sv */
// ----------------------------------------
// Far side: modem pins and serial lines
// ----------------------------------------
module uq_modem_model (
  // Clock
  input wire logic clk_sys,
  // Commanded pin levels from the bench
  input wire logic [3:0] set_cts,
  input wire logic [3:0] set_dsr,
  input wire logic [3:0] set_ri,
  input wire logic [3:0] set_cd,
  // Modem pins toward the block
  output logic [3:0] cts_n,
  output logic [3:0] dsr_n,
  output logic [3:0] ri_n,
  output logic [3:0] cd_n,
  // Serial lines from the block
  input wire logic [3:0] tx_out,
  input wire logic [3:0] infrared_tx_out,
  output logic line_quiet
);
  timeunit 1ns;
  timeprecision 1ps;

  // One process owns every output; pulled-up lines start inactive
  initial begin
    cts_n = 4'hF;
    dsr_n = 4'hF;
    ri_n = 4'hF;
    cd_n = 4'hF;
    line_quiet = 1'b1;
    forever begin
      @(posedge clk_sys);
      cts_n <= set_cts;
      dsr_n <= set_dsr;
      ri_n <= set_ri;
      cd_n <= set_cd;
      // Opposite edge: outputs settled, reset already applied at first edge
      @(negedge clk_sys);
      if (tx_out !== 4'hF || infrared_tx_out !== 4'h0) begin
        line_quiet <= 1'b0;
      end
    end
  end
endmodule

/* testbench/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import uq_pkg::*;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  uq_apb_req_t apb_req = '0;
  uq_apb_rsp_t apb_rsp;
  logic [3:0] set_cts = 4'h5;
  logic [3:0] set_dsr = 4'h3;
  logic [3:0] set_ri = 4'hF;
  logic [3:0] set_cd = 4'h9;
  logic [3:0] cts_n, dsr_n, ri_n, cd_n, tx_out, infrared_tx_out, rts_n, dtr_n;
  logic [3:0] rx_dma_ready_n, tx_dma_ready_n, int_out, int_oe_n;
  logic irq_n, irq, line_quiet;
  logic bus_style_motorola = 1'b1;
  logic irq_style_select = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic err;
  logic [4:0] rix [14] = '{UQ_IX_INT_EN, UQ_IX_FIFO_CTL, UQ_IX_INT_STAT, UQ_IX_LINE_CTL,
    UQ_IX_MODEM_CTL, UQ_IX_LINE_STAT, UQ_IX_SCRATCH, UQ_IX_FIFO_LVL, UQ_IX_FEAT_CTL,
    UQ_IX_ENH_FEAT, UQ_IX_RESUME1, UQ_IX_RESUME2, UQ_IX_PAUSE1, UQ_IX_PAUSE2};
  logic [7:0] rexp [14] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hFF, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #20 clk_sys = ~clk_sys;

  uq_quad_uart dut_u (.clk_sys, .reset, .apb_req, .apb_rsp, .cts_n, .dsr_n, .ri_n, .cd_n,
    .bus_style_motorola, .irq_style_select, .tx_out, .infrared_tx_out, .rts_n, .dtr_n,
    .rx_dma_ready_n, .tx_dma_ready_n, .int_out, .int_oe_n, .irq_n, .irq);

  uq_modem_model model_u (.clk_sys, .set_cts, .set_dsr, .set_ri, .set_cd, .cts_n, .dsr_n,
    .ri_n, .cd_n, .tx_out, .infrared_tx_out, .line_quiet);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  function automatic logic [11:0] addr(input int ch, input logic [4:0] ix);
    return 12'(ch * 128) + 12'({ix, 2'b00});
  endfunction

  // Waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, wd}};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string msg);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp}, msg);
  endtask

  function automatic logic [7:0] msr_hi(input int ch);
    return {~set_cd[ch], ~set_ri[ch], ~set_dsr[ch], ~set_cts[ch], 4'h0};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults(input string name);
    for (int ch = 0; ch < 4; ch++) begin
      for (int i = 0; i < 14; i++) begin
        rdc(addr(ch, rix[i]), rexp[i], "register reset value");
      end
      rdc(addr(ch, UQ_IX_MODEM_STAT), msr_hi(ch), "modem status reset");
    end
    rdc(UQ_OFS_SUMMARY, 8'hFF, "ready summary");
    chk({28'h0, tx_out}, 32'hF, "tx idle");
    chk({28'h0, infrared_tx_out}, 32'h0, "infrared idle");
    chk({24'h0, rts_n, dtr_n}, 32'hFF, "rts dtr");
    chk({24'h0, rx_dma_ready_n, tx_dma_ready_n}, 32'hF0, "dma ready");
    chk({24'h0, int_oe_n, int_out}, 32'hF0, "int floating");
    chk({31'h0, irq_n}, 32'h1, "shared irq");
    $display("test %s done", name);
  endtask

  task automatic t_enhanced;
    apb(1'b1, addr(1, UQ_IX_INT_EN), 8'hF3);
    rdc(addr(1, UQ_IX_INT_EN), 8'h03, "ier upper locked");
    apb(1'b1, addr(1, UQ_IX_MODEM_CTL), 8'hE3);
    rdc(addr(1, UQ_IX_MODEM_CTL), 8'h03, "mcr upper locked");
    chk({24'h0, rts_n, dtr_n}, 32'hDD, "rts dtr follow mcr");
    apb(1'b1, addr(2, UQ_IX_SCRATCH), 8'h5A);
    apb(1'b1, addr(3, UQ_IX_LINE_CTL), 8'h1B);
    apb(1'b1, addr(3, UQ_IX_PAUSE2), 8'h13);
    repeat (10) @(posedge clk_sys);
    rdc(addr(2, UQ_IX_SCRATCH), 8'h5A, "scratch holds");
    rdc(addr(0, UQ_IX_SCRATCH), 8'hFF, "other channel untouched");
    rdc(12'h300, 8'h00, "unmapped read");
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test enhanced done");
  endtask

  task automatic t_irq;
    int n;
    apb(1'b1, UQ_OFS_IRQ_MASK, 8'h01);
    @(posedge clk_sys);
    set_cts <= set_cts ^ 4'h3;
    n = 0;
    while (irq !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, irq}, 32'h1, "irq on unmasked event");
    rdc(UQ_OFS_IRQ_STAT, 8'h03, "irq status sticky");
    rdc(addr(0, UQ_IX_MODEM_STAT), msr_hi(0) | 8'h01, "cts change bit");
    apb(1'b1, UQ_OFS_IRQ_STAT, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0, "masked bit keeps irq low");
    rdc(UQ_OFS_IRQ_STAT, 8'h02, "w1c clears one bit");
    apb(1'b1, UQ_OFS_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1, "unmask raises irq");
    // Channel 1 still holds its change bit; enabling it makes the channel pending
    apb(1'b1, addr(1, UQ_IX_INT_EN), 8'h08);
    rdc(addr(1, UQ_IX_INT_STAT), 8'h00, "pending clears idle bit");
    chk({31'h0, irq_n}, 32'h0, "shared irq follows pending");
    chk({28'h0, int_out}, 32'h2, "channel interrupt level");
    irq_style_select <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({31'h0, irq_n}, 32'h1, "select high keeps irq_n idle");
    bus_style_motorola <= 1'b0;
    irq_style_select <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({31'h0, irq_n}, 32'h1, "Intel style keeps irq_n idle");
    bus_style_motorola <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({31'h0, irq_n}, 32'h0, "Motorola style drives irq_n");
    $display("test interrupt done");
  endtask

  // Second reset with dirty registers and a pending change bit
  task automatic t_rereset;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_defaults("second reset");
    rdc(UQ_OFS_IRQ_STAT, 8'h00, "irq status cleared");
    chk({31'h0, irq}, 32'h0, "irq low after reset");
    $display("test rereset done");
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Run needs about 500 cycles; the 20000-cycle limit leaves wide margin
  initial begin
    #800000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_defaults("reset defaults");
    t_enhanced();
    t_irq();
    t_rereset();
    chk({31'h0, line_quiet}, 32'h1, "serial lines stayed idle");
    tally_and_finish();
  end
endmodule
